// [core/mcrb_pkg.sv]
// Package of offsets, field positions and reset values for the MAC control register bank
package mcrb_pkg;
  // Register word indices; the byte address is four times the index
  localparam logic [15:0] IDX_STATUS = 16'h2180;
  localparam logic [15:0] IDX_CIPHER_RUN = 16'h218e;
  localparam logic [15:0] IDX_ENGINE_RESET = 16'h2190;
  localparam logic [15:0] IDX_RX_CONTROL = 16'h2191;
  localparam logic [15:0] IDX_ACK_SEQ = 16'h2192;
  localparam logic [15:0] IDX_SECURITY = 16'h2193;
  localparam logic [15:0] IDX_IRQ_STATUS = 16'h21a0;
  localparam logic [15:0] IDX_IRQ_MASK = 16'h21a1;
  // Status bit positions
  localparam int STS_CRC_OK = 0;
  localparam int STS_CIPHER_DONE = 4;
  // Cipher run bit
  localparam int RUN_GO = 0;
  // Engine reset bits
  localparam int INIT_FIFO_BIT = 7;
  localparam int RST_TX_BIT = 6;
  localparam int RST_RX_BIT = 5;
  localparam int RST_AES_BIT = 4;
  // Receive control bits
  localparam int CTL_ACK_FILT = 4;
  localparam int CTL_COORD = 3;
  localparam int CTL_ADDR_FILT = 2;
  localparam int CTL_CRC_FILT = 1;
  // Security register key select bit
  localparam int PROT_KEYSEL = 7;
  // Interrupt status bits
  localparam int IRQ_RX = 0;
  localparam int IRQ_CIPHER = 1;
  // Reset values
  localparam logic [7:0] RST_VAL_ENGINE = 8'h00;
  localparam logic [7:0] RST_VAL_CTRL = 8'h06;
  localparam logic [7:0] RST_VAL_ACK_SEQ = 8'h00;
  localparam logic [7:0] RST_VAL_PROT = 8'h00;
  // Writable masks
  localparam logic [7:0] MASK_ENGINE = 8'hf0;
  localparam logic [7:0] MASK_CTRL = 8'h1e;
  localparam logic [1:0] MASK_IRQ = 2'h3;
endpackage : mcrb_pkg

// [core/mcrb_rx_filter.sv]
// Receive interrupt filter deciding whether a finished packet raises an event
`timescale 1ns/1ns
`default_nettype none
module mcrb_rx_filter (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Packet report from the receiver
  input wire logic pkt_done,
  input wire logic pkt_crc_good,
  input wire logic pkt_addr_match,
  input wire logic pkt_is_ack,
  input wire logic [7:0] pkt_seq,
  // Filter settings
  input wire logic ack_sequence_filter,
  input wire logic addr_filter,
  input wire logic crc_filter,
  input wire logic [7:0] expected_ack_sequence,
  // Filtered event
  output logic rx_event
);
  // Registered copy of the verdict
  typedef struct packed {
    logic event_q;
  } mcrb_flt_t;
  mcrb_flt_t state_ff;
  mcrb_flt_t nxt_state;
  logic drop;

  // Decide whether the packet is suppressed
  always_comb begin
    drop = 1'b0;
    if (crc_filter && !pkt_crc_good) begin
      drop = 1'b1;
    end
    if (addr_filter && !pkt_addr_match) begin
      drop = 1'b1;
    end
    if (ack_sequence_filter && pkt_is_ack && (pkt_seq != expected_ack_sequence)) begin
      drop = 1'b1;
    end
    nxt_state.event_q = pkt_done && !drop;
  end

  // Register the verdict
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign rx_event = state_ff.event_q;

  // Bad CRC under filter never yields an event
  property p_crc_drop;
    @(posedge pclk) disable iff (!presetn)
      (pkt_done && crc_filter && !pkt_crc_good) |=> !rx_event;
  endproperty
  a_crc_drop: assert property (p_crc_drop) else $error("crc filtered packet raised event");

  // Address mismatch under filter never yields an event
  property p_addr_drop;
    @(posedge pclk) disable iff (!presetn)
      (pkt_done && addr_filter && !pkt_addr_match) |=> !rx_event;
  endproperty
  a_addr_drop: assert property (p_addr_drop) else $error("address filtered packet raised event");

  // Wrong acknowledgement sequence under filter never yields an event
  property p_ack_drop;
    @(posedge pclk) disable iff (!presetn)
      (pkt_done && ack_sequence_filter && pkt_is_ack && pkt_seq != expected_ack_sequence) |=> !rx_event;
  endproperty
  a_ack_drop: assert property (p_ack_drop) else $error("ack filtered packet raised event");

  // With no filter enabled every packet gives an event
  property p_ack_unused;
    @(posedge pclk) disable iff (!presetn)
      (pkt_done && !ack_sequence_filter && !addr_filter && !crc_filter) |=> rx_event;
  endproperty
  a_ack_unused: assert property (p_ack_unused) else $error("unfiltered packet lost");
endmodule : mcrb_rx_filter
`default_nettype wire

// [core/mcrb_top.sv]
// APB register bank controlling the MAC engines, receive filters and standalone cipher
// What this block does
// - Set CRC pass flag on good checksum
// - Writing one starts standalone AES operation
// - Start bit self clears; register write only
// - Bit 7 initialises the packet FIFO
// - Bit 6 resets transmit state machine
// - Bit 5 resets receive state machine
// - Bit 4 initialises AES; low bits zero
// - Ack filter drops wrong sequence interrupts
// - Bit 3 enables coordinator functions
// - Address filter drops foreign packet interrupts
// - CRC filter drops bad packet interrupts
// - Expected sequence register, used under filter
// - Cipher done flag sticky until cleared
// - Key select picks key one or zero
`timescale 1ns/1ns
`default_nettype none
module mcrb_top (
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [17:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Receiver packet report
  input wire logic pkt_done,
  input wire logic pkt_crc_good,
  input wire logic pkt_addr_match,
  input wire logic pkt_is_ack,
  input wire logic [7:0] pkt_seq,
  // Cipher engine handshake
  input wire logic cipher_finished,
  output logic standalone_cipher_go,
  output logic standalone_key_select,
  // Engine initialisation levels and coordinator enable
  output logic fifo_init,
  output logic transmit_fsm_init,
  output logic receive_fsm_init,
  output logic aes_init,
  output logic network_coordinator_enable,
  // Interrupt
  output logic irq
);
  // All register state
  typedef struct packed {
    logic go;
    logic crc_ok;
    logic cipher_done;
    logic [7:0] engine;
    logic [7:0] ctrl;
    logic [7:0] ack_seq;
    logic [7:0] prot;
    logic [1:0] irq_sts;
    logic [1:0] irq_msk;
    logic [31:0] rdata;
  } mcrb_regs_t;
  mcrb_regs_t regs_ff;
  mcrb_regs_t nxt_regs;
  logic wr_en;
  logic rd_en;
  logic rx_event;
  logic [7:0] wbyte;
  logic hit;

  // Map a word byte address to its printed index
  function automatic logic [15:0] word_index(input logic [17:0] a);
    word_index = a[17:2];
  endfunction : word_index

  // Check that an index is a mapped register
  function automatic logic is_mapped(input logic [15:0] i);
    is_mapped = (i == mcrb_pkg::IDX_STATUS) || (i == mcrb_pkg::IDX_CIPHER_RUN) ||
                (i == mcrb_pkg::IDX_ENGINE_RESET) || (i == mcrb_pkg::IDX_RX_CONTROL) ||
                (i == mcrb_pkg::IDX_ACK_SEQ) || (i == mcrb_pkg::IDX_SECURITY) ||
                (i == mcrb_pkg::IDX_IRQ_STATUS) || (i == mcrb_pkg::IDX_IRQ_MASK);
  endfunction : is_mapped

  // Receive interrupt filter
  mcrb_rx_filter i_mcrb_rx_filter (
    .pclk(pclk),
    .presetn(presetn),
    .pkt_done(pkt_done),
    .pkt_crc_good(pkt_crc_good),
    .pkt_addr_match(pkt_addr_match),
    .pkt_is_ack(pkt_is_ack),
    .pkt_seq(pkt_seq),
    .ack_sequence_filter(regs_ff.ctrl[mcrb_pkg::CTL_ACK_FILT]),
    .addr_filter(regs_ff.ctrl[mcrb_pkg::CTL_ADDR_FILT]),
    .crc_filter(regs_ff.ctrl[mcrb_pkg::CTL_CRC_FILT]),
    .expected_ack_sequence(regs_ff.ack_seq),
    .rx_event(rx_event)
  );

  // Bus strobes: zero wait state slave
  assign hit = is_mapped(word_index(paddr));
  assign wr_en = psel && penable && pwrite && hit;
  assign rd_en = psel && !penable && !pwrite;
  assign wbyte = pwdata[7:0];

  // Next state of every register
  always_comb begin
    nxt_regs = regs_ff;
    // Start pulse lasts one cycle and clears itself
    nxt_regs.go = 1'b0;
    // CRC pass flag follows each finished packet
    if (pkt_done) begin
      nxt_regs.crc_ok = pkt_crc_good;
    end
    // Writes
    if (wr_en) begin
      case (word_index(paddr))
        mcrb_pkg::IDX_STATUS: begin
          // Writing one clears the done flag
          if (wbyte[mcrb_pkg::STS_CIPHER_DONE]) begin
            nxt_regs.cipher_done = 1'b0;
          end
        end
        mcrb_pkg::IDX_CIPHER_RUN: begin
          nxt_regs.go = wbyte[mcrb_pkg::RUN_GO];
        end
        mcrb_pkg::IDX_ENGINE_RESET: begin
          nxt_regs.engine = wbyte & mcrb_pkg::MASK_ENGINE;
        end
        mcrb_pkg::IDX_RX_CONTROL: begin
          // Bit 0 and reserved bits are not stored
          nxt_regs.ctrl = wbyte & mcrb_pkg::MASK_CTRL;
        end
        mcrb_pkg::IDX_ACK_SEQ: begin
          nxt_regs.ack_seq = wbyte;
        end
        mcrb_pkg::IDX_SECURITY: begin
          nxt_regs.prot = wbyte;
        end
        mcrb_pkg::IDX_IRQ_STATUS: begin
          nxt_regs.irq_sts = regs_ff.irq_sts & ~(wbyte[1:0] & mcrb_pkg::MASK_IRQ);
        end
        mcrb_pkg::IDX_IRQ_MASK: begin
          nxt_regs.irq_msk = wbyte[1:0];
        end
        default: begin
          nxt_regs.go = 1'b0;
        end
      endcase
    end
    // Hardware sets win over software clears
    if (cipher_finished) begin
      nxt_regs.cipher_done = 1'b1;
      nxt_regs.irq_sts[mcrb_pkg::IRQ_CIPHER] = 1'b1;
    end
    if (rx_event) begin
      nxt_regs.irq_sts[mcrb_pkg::IRQ_RX] = 1'b1;
    end
    // Read data captured in the setup phase
    if (rd_en) begin
      case (word_index(paddr))
        mcrb_pkg::IDX_STATUS: begin
          nxt_regs.rdata = {27'h0, regs_ff.cipher_done, 3'h0, regs_ff.crc_ok};
        end
        mcrb_pkg::IDX_ENGINE_RESET: begin
          nxt_regs.rdata = {24'h0, regs_ff.engine};
        end
        mcrb_pkg::IDX_RX_CONTROL: begin
          nxt_regs.rdata = {24'h0, regs_ff.ctrl};
        end
        mcrb_pkg::IDX_ACK_SEQ: begin
          nxt_regs.rdata = {24'h0, regs_ff.ack_seq};
        end
        mcrb_pkg::IDX_SECURITY: begin
          nxt_regs.rdata = {24'h0, regs_ff.prot};
        end
        mcrb_pkg::IDX_IRQ_STATUS: begin
          nxt_regs.rdata = {30'h0, regs_ff.irq_sts};
        end
        mcrb_pkg::IDX_IRQ_MASK: begin
          nxt_regs.rdata = {30'h0, regs_ff.irq_msk};
        end
        default: begin
          // Write-only and unmapped words read zero
          nxt_regs.rdata = 32'h0;
        end
      endcase
    end
  end

  // Register everything
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      regs_ff.go <= 1'b0;
      regs_ff.crc_ok <= 1'b0;
      regs_ff.cipher_done <= 1'b0;
      regs_ff.engine <= mcrb_pkg::RST_VAL_ENGINE;
      regs_ff.ctrl <= mcrb_pkg::RST_VAL_CTRL;
      regs_ff.ack_seq <= mcrb_pkg::RST_VAL_ACK_SEQ;
      regs_ff.prot <= mcrb_pkg::RST_VAL_PROT;
      regs_ff.irq_sts <= 2'h0;
      regs_ff.irq_msk <= 2'h0;
      regs_ff.rdata <= 32'h0;
    end else begin
      regs_ff <= nxt_regs;
    end
  end

  // Outputs
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign prdata = regs_ff.rdata;
  assign standalone_cipher_go = regs_ff.go;
  assign standalone_key_select = regs_ff.prot[mcrb_pkg::PROT_KEYSEL];
  assign fifo_init = regs_ff.engine[mcrb_pkg::INIT_FIFO_BIT];
  assign transmit_fsm_init = regs_ff.engine[mcrb_pkg::RST_TX_BIT];
  assign receive_fsm_init = regs_ff.engine[mcrb_pkg::RST_RX_BIT];
  assign aes_init = regs_ff.engine[mcrb_pkg::RST_AES_BIT];
  assign network_coordinator_enable = regs_ff.ctrl[mcrb_pkg::CTL_COORD];
  assign irq = |(regs_ff.irq_sts & regs_ff.irq_msk);

  // A start pulse lasts one cycle unless a write follows it
  property p_go_pulse;
    @(posedge pclk) disable iff (!presetn)
      standalone_cipher_go |=> !standalone_cipher_go || $past(wr_en);
  endproperty
  a_go_pulse: assert property (p_go_pulse) else $error("start bit did not self clear");

  // A start write gives the pulse on the next cycle
  property p_go_start;
    @(posedge pclk) disable iff (!presetn)
      (wr_en && word_index(paddr) == mcrb_pkg::IDX_CIPHER_RUN && pwdata[0]) |=> standalone_cipher_go;
  endproperty
  a_go_start: assert property (p_go_start) else $error("start write gave no pulse");

  // Cipher finish leaves done set
  property p_done_set;
    @(posedge pclk) disable iff (!presetn)
      cipher_finished |=> regs_ff.cipher_done;
  endproperty
  a_done_set: assert property (p_done_set) else $error("done flag not set");

  // Done stays set without a clearing write
  property p_done_hold;
    @(posedge pclk) disable iff (!presetn)
      (regs_ff.cipher_done && !wr_en) |=> regs_ff.cipher_done;
  endproperty
  a_done_hold: assert property (p_done_hold) else $error("done flag dropped");

  // Good packet sets CRC flag
  property p_crc_flag;
    @(posedge pclk) disable iff (!presetn)
      (pkt_done && pkt_crc_good) |=> regs_ff.crc_ok;
  endproperty
  a_crc_flag: assert property (p_crc_flag) else $error("crc flag not set");

  // FIFO init level holds until a write
  property p_init_hold;
    @(posedge pclk) disable iff (!presetn)
      (fifo_init && !wr_en) |=> fifo_init;
  endproperty
  a_init_hold: assert property (p_init_hold) else $error("fifo init dropped alone");

  // Low engine bits always zero
  property p_engine_low;
    @(posedge pclk) disable iff (!presetn)
      regs_ff.engine[3:0] == 4'h0;
  endproperty
  a_engine_low: assert property (p_engine_low) else $error("reserved engine bits set");

  // Key select follows the security write
  property p_keysel;
    @(posedge pclk) disable iff (!presetn)
      (wr_en && word_index(paddr) == mcrb_pkg::IDX_SECURITY) |=> standalone_key_select == $past(pwdata[7]);
  endproperty
  a_keysel: assert property (p_keysel) else $error("key select mismatch");

  // No start pulse without a start write
  property p_go_quiet;
    @(posedge pclk) disable iff (!presetn)
      !(wr_en && word_index(paddr) == mcrb_pkg::IDX_CIPHER_RUN) |=> !standalone_cipher_go;
  endproperty
  a_go_quiet: assert property (p_go_quiet) else $error("start pulse without write");

  // The write-only run word reads back as zero
  property p_run_reads_zero;
    @(posedge pclk) disable iff (!presetn)
      (rd_en && word_index(paddr) == mcrb_pkg::IDX_CIPHER_RUN) |=> prdata == 32'h0;
  endproperty
  a_run_reads_zero: assert property (p_run_reads_zero) else $error("run word read nonzero");

  // Bad packet leaves the CRC pass flag clear
  property p_crc_clear;
    @(posedge pclk) disable iff (!presetn)
      (pkt_done && !pkt_crc_good) |=> !regs_ff.crc_ok;
  endproperty
  a_crc_clear: assert property (p_crc_clear) else $error("crc flag set on bad packet");

  // CRC pass flag only moves with a finished packet
  property p_crc_hold;
    @(posedge pclk) disable iff (!presetn)
      !pkt_done |=> $stable(regs_ff.crc_ok);
  endproperty
  a_crc_hold: assert property (p_crc_hold) else $error("crc flag changed without packet");

  // FIFO init level takes the written bit
  property p_fifo_write;
    @(posedge pclk) disable iff (!presetn)
      (wr_en && word_index(paddr) == mcrb_pkg::IDX_ENGINE_RESET) |=>
        fifo_init == $past(pwdata[mcrb_pkg::INIT_FIFO_BIT]);
  endproperty
  a_fifo_write: assert property (p_fifo_write) else $error("fifo init mismatch");

  // Transmit init level takes the written bit
  property p_tx_write;
    @(posedge pclk) disable iff (!presetn)
      (wr_en && word_index(paddr) == mcrb_pkg::IDX_ENGINE_RESET) |=>
        transmit_fsm_init == $past(pwdata[mcrb_pkg::RST_TX_BIT]);
  endproperty
  a_tx_write: assert property (p_tx_write) else $error("transmit init mismatch");

  // Receive init level takes the written bit
  property p_rx_write;
    @(posedge pclk) disable iff (!presetn)
      (wr_en && word_index(paddr) == mcrb_pkg::IDX_ENGINE_RESET) |=>
        receive_fsm_init == $past(pwdata[mcrb_pkg::RST_RX_BIT]);
  endproperty
  a_rx_write: assert property (p_rx_write) else $error("receive init mismatch");

  // Cipher init level takes the written bit
  property p_aes_write;
    @(posedge pclk) disable iff (!presetn)
      (wr_en && word_index(paddr) == mcrb_pkg::IDX_ENGINE_RESET) |=>
        aes_init == $past(pwdata[mcrb_pkg::RST_AES_BIT]);
  endproperty
  a_aes_write: assert property (p_aes_write) else $error("cipher init mismatch");

  // Coordinator enable takes the written bit
  property p_coord_write;
    @(posedge pclk) disable iff (!presetn)
      (wr_en && word_index(paddr) == mcrb_pkg::IDX_RX_CONTROL) |=>
        network_coordinator_enable == $past(pwdata[mcrb_pkg::CTL_COORD]);
  endproperty
  a_coord_write: assert property (p_coord_write) else $error("coordinator enable mismatch");

  // Expected sequence takes the whole written byte
  property p_ack_seq_write;
    @(posedge pclk) disable iff (!presetn)
      (wr_en && word_index(paddr) == mcrb_pkg::IDX_ACK_SEQ) |=> regs_ff.ack_seq == $past(pwdata[7:0]);
  endproperty
  a_ack_seq_write: assert property (p_ack_seq_write) else $error("expected sequence mismatch");

  // A clearing write drops the done flag when no finish collides
  property p_done_clear;
    @(posedge pclk) disable iff (!presetn)
      (regs_ff.cipher_done && wr_en && word_index(paddr) == mcrb_pkg::IDX_STATUS &&
       pwdata[mcrb_pkg::STS_CIPHER_DONE] && !cipher_finished) |=> !regs_ff.cipher_done;
  endproperty
  a_done_clear: assert property (p_done_clear) else $error("done flag not cleared");
endmodule : mcrb_top
`default_nettype wire

// [tb/mac_control_register_bank_bench.sv]
// Self-checking bench driving the MAC control register bank over APB and its packet and cipher ports
`timescale 1ns/1ns
`default_nettype none
module mac_control_register_bank_bench;
  // Clock, reset and APB master signals
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [17:0] paddr = 18'h00000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  // Receiver report and cipher handshake
  logic pkt_done = 1'b0;
  logic pkt_crc_good = 1'b0;
  logic pkt_addr_match = 1'b0;
  logic pkt_is_ack = 1'b0;
  logic [7:0] pkt_seq = 8'h00;
  logic cipher_finished = 1'b0;
  // Observed outputs
  logic go, keysel, fifo_i, tx_i, rx_i, aes_i, coord, irq;
  // Bookkeeping
  int err_total = 0;
  int samples_checked = 0;
  int go_count = 0;
  logic [31:0] rd;
  logic er;

  // 125 MHz clock
  always #4 pclk = ~pclk;

  // Counts start pulses seen at rising edges
  always @(posedge pclk) begin
    if (go === 1'b1) go_count++;
  end

  mcrb_top i_mcrb_top (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pkt_done(pkt_done), .pkt_crc_good(pkt_crc_good), .pkt_addr_match(pkt_addr_match),
    .pkt_is_ack(pkt_is_ack), .pkt_seq(pkt_seq), .cipher_finished(cipher_finished),
    .standalone_cipher_go(go), .standalone_key_select(keysel), .fifo_init(fifo_i),
    .transmit_fsm_init(tx_i), .receive_fsm_init(rx_i), .aes_init(aes_i),
    .network_coordinator_enable(coord), .irq(irq)
  );

  // Prints counts and the verdict, then stops
  task automatic conclude;
    $display("Comparisons %0d, mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : conclude

  // Compares one value and reports a mismatch
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer; holds the request until pready is sampled high
  task automatic apb(input logic wr_en, input logic [15:0] idx, input logic [7:0] wd,
                     output logic [31:0] rdo, output logic erro);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr_en;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h000000, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdo = prdata;
    erro = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Register write
  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d, rd, er);
    // Let the written register settle before outputs are compared
    @(negedge pclk);
  endtask : wr

  // Register read compared with an expected word
  task automatic rchk(input logic [15:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 8'h00, rd, er);
    chk(rd, exp);
  endtask : rchk

  // Sends one packet report and checks the filtered event, interrupt line and pass flag
  task automatic pkt(input logic crc, input logic am, input logic ack, input logic [7:0] seq, input logic ev);
    wr(mcrb_pkg::IDX_IRQ_STATUS, 8'h01);
    @(posedge pclk);
    pkt_done <= 1'b1;
    pkt_crc_good <= crc;
    pkt_addr_match <= am;
    pkt_is_ack <= ack;
    pkt_seq <= seq;
    @(posedge pclk);
    pkt_done <= 1'b0;
    repeat (3) @(posedge pclk);
    rchk(mcrb_pkg::IDX_IRQ_STATUS, {31'h0, ev});
    chk({31'h0, irq}, {31'h0, ev});
    rchk(mcrb_pkg::IDX_STATUS, {31'h0, crc});
  endtask : pkt

  // Watchdog against a hung handshake
  initial begin
    #200000;
    err_total++;
    conclude();
  end

  // Main test sequence
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    chk({24'h0, go, keysel, fifo_i, tx_i, rx_i, aes_i, coord, irq}, 32'h0);
    rchk(mcrb_pkg::IDX_ENGINE_RESET, 32'h00);
    rchk(mcrb_pkg::IDX_RX_CONTROL, 32'h06);
    rchk(mcrb_pkg::IDX_ACK_SEQ, 32'h00);
    rchk(mcrb_pkg::IDX_CIPHER_RUN, 32'h00);
    // Each init bit alone drives only its own engine and holds
    for (int b = 4; b < 8; b++) begin
      wr(mcrb_pkg::IDX_ENGINE_RESET, 8'h01 << b);
      repeat (6) @(posedge pclk);
      chk({28'h0, fifo_i, tx_i, rx_i, aes_i}, 32'h1 << (b - 4));
      rchk(mcrb_pkg::IDX_ENGINE_RESET, 32'h1 << b);
    end
    wr(mcrb_pkg::IDX_ENGINE_RESET, 8'hff);
    rchk(mcrb_pkg::IDX_ENGINE_RESET, 32'hf0);
    wr(mcrb_pkg::IDX_ENGINE_RESET, 8'h00);
    chk({28'h0, fifo_i, tx_i, rx_i, aes_i}, 32'h0);
    // Control: reserved bits are not stored; software keeps bit 0 at zero
    wr(mcrb_pkg::IDX_RX_CONTROL, 8'hfe);
    rchk(mcrb_pkg::IDX_RX_CONTROL, 32'h1e);
    chk({31'h0, coord}, 32'h1);
    wr(mcrb_pkg::IDX_ACK_SEQ, 8'ha5);
    rchk(mcrb_pkg::IDX_ACK_SEQ, 32'ha5);
    // Unmapped address is refused and reads zero
    apb(1'b0, 16'h2100, 8'h00, rd, er);
    chk(rd, 32'h0);
    chk({31'h0, er}, 32'h1);
    chk({31'h0, pready}, 32'h1);
    // Standalone cipher with key one
    wr(mcrb_pkg::IDX_IRQ_MASK, 8'h03);
    wr(mcrb_pkg::IDX_SECURITY, 8'h80);
    chk({31'h0, keysel}, 32'h1);
    go_count = 0;
    wr(mcrb_pkg::IDX_CIPHER_RUN, 8'h01);
    repeat (4) @(posedge pclk);
    chk(go_count, 32'h1);
    rchk(mcrb_pkg::IDX_CIPHER_RUN, 32'h00);
    @(posedge pclk);
    cipher_finished <= 1'b1;
    @(posedge pclk);
    cipher_finished <= 1'b0;
    repeat (8) @(posedge pclk);
    rchk(mcrb_pkg::IDX_STATUS, 32'h10);
    rchk(mcrb_pkg::IDX_IRQ_STATUS, 32'h02);
    chk({31'h0, irq}, 32'h1);
    wr(mcrb_pkg::IDX_STATUS, 8'h10);
    rchk(mcrb_pkg::IDX_STATUS, 32'h00);
    wr(mcrb_pkg::IDX_IRQ_STATUS, 8'h02);
    chk({31'h0, irq}, 32'h0);
    wr(mcrb_pkg::IDX_SECURITY, 8'h00);
    chk({31'h0, keysel}, 32'h0);
    // Receive filters
    wr(mcrb_pkg::IDX_RX_CONTROL, 8'h06);
    pkt(1'b1, 1'b1, 1'b0, 8'h00, 1'b1);
    pkt(1'b0, 1'b1, 1'b0, 8'h00, 1'b0);
    pkt(1'b1, 1'b0, 1'b0, 8'h00, 1'b0);
    wr(mcrb_pkg::IDX_RX_CONTROL, 8'h00);
    pkt(1'b0, 1'b1, 1'b0, 8'h00, 1'b1);
    pkt(1'b1, 1'b0, 1'b0, 8'h00, 1'b1);
    pkt(1'b1, 1'b1, 1'b1, 8'h5a, 1'b1);
    wr(mcrb_pkg::IDX_RX_CONTROL, 8'h10);
    pkt(1'b1, 1'b1, 1'b1, 8'ha5, 1'b1);
    pkt(1'b1, 1'b1, 1'b1, 8'h5a, 1'b0);
    pkt(1'b1, 1'b1, 1'b0, 8'h5a, 1'b1);
    // Masked event stays pending without raising the line
    wr(mcrb_pkg::IDX_IRQ_MASK, 8'h00);
    wr(mcrb_pkg::IDX_IRQ_STATUS, 8'h01);
    rchk(mcrb_pkg::IDX_IRQ_STATUS, 32'h00);
    @(posedge pclk);
    pkt_done <= 1'b1;
    @(posedge pclk);
    pkt_done <= 1'b0;
    repeat (3) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    rchk(mcrb_pkg::IDX_IRQ_STATUS, 32'h01);
    wr(mcrb_pkg::IDX_IRQ_MASK, 8'h01);
    chk({31'h0, irq}, 32'h1);
    wr(mcrb_pkg::IDX_IRQ_STATUS, 8'h01);
    chk({31'h0, irq}, 32'h0);
    conclude();
  end
endmodule : mac_control_register_bank_bench
`default_nettype wire
